// ---- dv/memory_map_decoder_tb.sv ----
/*
 * Self-checking testbench of the memory map decoder: APB configuration plus CPU accesses.
 * Assumes the CPU model in mmd_cpu_model and the package mmd_pkg.
 */
`timescale 1ns/10ps
module memory_map_decoder_tb;
   localparam logic [2:0] T_IF = mmd_pkg::MMD_TGT_IFLASH;
   localparam logic [2:0] T_XF = mmd_pkg::MMD_TGT_XFLASH;
   localparam logic [2:0] T_IR = mmd_pkg::MMD_TGT_DUAL_PORT_INT_RAM;
   localparam logic [2:0] T_X1 = mmd_pkg::MMD_TGT_EXT_RAM_AREA1;
   localparam logic [2:0] T_X2 = mmd_pkg::MMD_TGT_EXT_RAM_AREA2;
   localparam logic [2:0] T_EX = mmd_pkg::MMD_TGT_EXT;
   localparam logic [2:0] T_BL = mmd_pkg::MMD_TGT_BLOCKED;
   localparam logic [3:0] RD = 4'h0;
   localparam logic [3:0] WR = 4'h8;
   localparam logic [3:0] BY = 4'h4;
   localparam logic [7:0] SYS = mmd_pkg::OFS_SYS_CFG;
   localparam logic [7:0] XPC = mmd_pkg::OFS_XPER_CFG;

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic boot_mode = 1'b0;
   logic end_of_init_instr = 1'b0;
   logic [3:0] bank_busy = 4'h0;
   logic cpu_req, cpu_write, cpu_byte, cpu_bitop, cpu_stack;
   logic [23:0] cpu_addr;
   logic cpu_ack, cpu_err, cpu_byte_out;
   logic [2:0] cpu_tgt;
   logic [1:0] flash_bank;
   logic [3:0] flash_blk;
   int n_mismatch = 0;
   int tests_run = 0;

   always #25 pclk = ~pclk;

   mmd_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .boot_mode(boot_mode), .end_of_init_instr(end_of_init_instr), .bank_busy(bank_busy),
      .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_write(cpu_write), .cpu_byte(cpu_byte),
      .cpu_bitop(cpu_bitop), .cpu_stack(cpu_stack), .cpu_ack(cpu_ack), .cpu_tgt(cpu_tgt),
      .cpu_err(cpu_err), .cpu_byte_out(cpu_byte_out), .flash_bank(flash_bank), .flash_blk(flash_blk));

   mmd_cpu_model u_cpu (.pclk(pclk), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
      .cpu_byte(cpu_byte), .cpu_bitop(cpu_bitop), .cpu_stack(cpu_stack), .cpu_ack(cpu_ack),
      .cpu_tgt(cpu_tgt), .cpu_err(cpu_err), .cpu_byte_out(cpu_byte_out), .flash_bank(flash_bank),
      .flash_blk(flash_blk));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
                         input logic eerr);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h00000000, r, e);
      chk(r & mask, exp, "register read");
      chk({31'h0, e}, {31'h0, eerr}, "slave error");
   endtask

   task automatic acc(input logic [23:0] a, input logic [3:0] q, input logic [2:0] etgt,
                      input logic [1:0] ebank, input logic [3:0] eblk, input int elat);
      logic [2:0] tgt;
      logic err, bo;
      logic [1:0] bank;
      logic [3:0] blk;
      int lat;
      u_cpu.access(a, q, tgt, err, bo, bank, blk, lat);
      chk({29'h0, tgt}, {29'h0, etgt}, "target");
      chk({31'h0, err}, {31'h0, etgt == T_BL}, "error flag");
      chk({31'h0, bo}, {31'h0, q[2]}, "byte flag");
      if (etgt == T_IF || etgt == T_XF) chk({26'h0, bank, blk}, {26'h0, ebank, eblk}, "flash block");
      if (elat > 0) chk(32'(lat), 32'(elat), "latency");
      else chk({31'h0, lat > 0}, 32'h1, "acknowledge");
   endtask

   task automatic t_regs;
      rd_chk(SYS, 32'hffffffff, mmd_pkg::SYS_CFG_RST, 1'b0);
      rd_chk(XPC, 32'hffffffff, mmd_pkg::XPER_CFG_RST, 1'b0);
      rd_chk(8'h0c, 32'hffffffff, 32'h00000000, 1'b1);
   endtask

   task automatic t_default_map;
      acc(24'h000000, RD, T_IF, 2'h0, 4'h0, 2);
      acc(24'h006000, BY, T_IF, 2'h0, 4'h3, 0);
      acc(24'h010000, RD, T_EX, 2'h0, 4'h0, 0);
      acc(24'h018000, RD, T_IF, 2'h0, 4'h4, 0);
      acc(24'h060000, RD, T_IF, 2'h0, 4'h9, 0);
      acc(24'h070000, RD, T_IF, 2'h1, 4'ha, 0);
      acc(24'h080000, RD, T_IF, 2'h1, 4'hb, 0);
      acc(24'h090000, RD, T_EX, 2'h0, 4'h0, 0);
      acc(24'h00e000, RD, T_EX, 2'h0, 4'h0, 0);
      acc(24'h0f0000, RD, T_EX, 2'h0, 4'h0, 0);
      acc(24'h00c000, RD, T_EX, 2'h0, 4'h0, 0);
      acc(24'h00f600, BY, T_IR, 2'h0, 4'h0, 0);
      acc(24'h100000, WR, T_EX, 2'h0, 4'h0, 0);
      acc(24'hffffff, BY, T_EX, 2'h0, 4'h0, 0);
   endtask

   task automatic t_ext_regions;
      wr(XPC, 32'h0000002c);
      acc(24'h0e0000, RD, T_EX, 2'h0, 4'h0, 0);
      wr(SYS, 32'h00000014);
      wr(XPC, 32'h0000000c);
      acc(24'h090000, RD, T_EX, 2'h0, 4'h0, 0);
      wr(XPC, 32'h0000002c);
      acc(24'h090000, RD, T_XF, 2'h2, 4'h0, 2);
      acc(24'h0b0000, BY, T_XF, 2'h2, 4'h2, 0);
      acc(24'h0c0000, RD, T_XF, 2'h3, 4'h3, 0);
      acc(24'h0e0000, RD, T_XF, 2'h3, 4'h5, 0);
      acc(24'h080000, RD, T_IF, 2'h1, 4'hb, 0);
      acc(24'h00e7fe, WR, T_X1, 2'h0, 4'h0, 2);
      acc(24'h0fffff, BY, T_X2, 2'h0, 4'h0, 2);
      acc(24'h0f0010, 4'h2, T_BL, 2'h0, 4'h0, 0);
      acc(24'h00e010, 4'h1, T_BL, 2'h0, 4'h0, 0);
      acc(24'h00f700, 4'h3, T_IR, 2'h0, 4'h0, 0);
      wr(XPC, 32'h00000028);
      acc(24'h00e000, RD, T_EX, 2'h0, 4'h0, 0);
      wr(SYS, 32'h00000004);
      acc(24'h080000, RD, T_BL, 2'h0, 4'h0, 0);
      acc(24'h020000, RD, T_EX, 2'h0, 4'h0, 0);
      wr(SYS, 32'h00000010);
      acc(24'h0f0000, RD, T_EX, 2'h0, 4'h0, 0);
   endtask

   task automatic t_busy_bank;
      bank_busy <= 4'h1;
      fork
         acc(24'h002000, RD, T_IF, 2'h0, 4'h1, 7);
         begin
            repeat (6) @(posedge pclk);
            bank_busy <= 4'h0;
         end
      join
      bank_busy <= 4'h2;
      acc(24'h002000, RD, T_IF, 2'h0, 4'h1, 2);
      bank_busy <= 4'h1;
      acc(24'h004000, WR, T_IF, 2'h0, 4'h2, 2);
      bank_busy <= 4'h0;
   endtask

   task automatic t_boot;
      boot_mode <= 1'b1;
      rd_chk(mmd_pkg::OFS_STATUS, 32'h00000020, 32'h00000020, 1'b0);
      acc(24'h001ffe, RD, T_IF, 2'h0, 4'hf, 0);
      boot_mode <= 1'b0;
      acc(24'h000000, RD, T_IF, 2'h0, 4'h0, 0);
   endtask

   task automatic t_remap;
      wr(SYS, 32'h00001010);
      acc(24'h012000, RD, T_IF, 2'h0, 4'h1, 0);
      acc(24'h000000, RD, T_EX, 2'h0, 4'h0, 0);
      @(posedge pclk);
      end_of_init_instr <= 1'b1;
      @(posedge pclk);
      end_of_init_instr <= 1'b0;
      wr(SYS, 32'h00000010);
      rd_chk(SYS, 32'hffffffff, 32'h00001010, 1'b0);
      rd_chk(mmd_pkg::OFS_STATUS, 32'h00000010, 32'h00000010, 1'b0);
      acc(24'h016000, RD, T_IF, 2'h0, 4'h3, 0);
   endtask

   task automatic print_verdict;
      $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_default_map();
      t_ext_regions();
      t_busy_bank();
      t_boot();
      t_remap();
      print_verdict();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      print_verdict();
   end
endmodule // memory_map_decoder_tb

// ---- dv/mmd_cpu_model.sv ----
/*
 * CPU core model for the memory map decoder: issues one access at a time and collects the answer.
 * Assumes the decoder acknowledges with a one-cycle cpu_ack and holds its target outputs after it.
 */
`timescale 1ns/10ps
module mmd_cpu_model (
   input wire logic pclk,
   output logic cpu_req,
   output logic [23:0] cpu_addr,
   output logic cpu_write,
   output logic cpu_byte,
   output logic cpu_bitop,
   output logic cpu_stack,
   input wire logic cpu_ack,
   input wire logic [2:0] cpu_tgt,
   input wire logic cpu_err,
   input wire logic cpu_byte_out,
   input wire logic [1:0] flash_bank,
   input wire logic [3:0] flash_blk
);
   initial begin
      cpu_req = 1'b0;
      cpu_addr = 24'h000000;
      {cpu_write, cpu_byte, cpu_bitop, cpu_stack} = 4'h0;
   end

   // Qualifiers q are {write, byte, bitop, stack}; lat counts edges from request to sampled ack.
   task automatic access(input logic [23:0] a, input logic [3:0] q, output logic [2:0] tgt,
                         output logic err, output logic bo, output logic [1:0] bank,
                         output logic [3:0] blk, output int lat);
      lat = -1;
      @(posedge pclk);
      cpu_req <= 1'b1;
      cpu_addr <= a;
      {cpu_write, cpu_byte, cpu_bitop, cpu_stack} <= q;
      for (int i = 1; i <= 100; i++) begin
         @(posedge pclk);
         if (cpu_ack === 1'b1) begin
            lat = i;
            break;
         end
      end
      tgt = cpu_tgt;
      err = cpu_err;
      bo = cpu_byte_out;
      bank = flash_bank;
      blk = flash_blk;
      // Released lines show the inverse so a stale value cannot pass for a held one.
      cpu_req <= 1'b0;
      cpu_addr <= ~a;
      {cpu_write, cpu_byte, cpu_bitop, cpu_stack} <= ~q;
   endtask
endmodule // mmd_cpu_model

// ---- include/mmd_cfg_if.sv ----
/*
 * Configuration and status carrier between the APB register file and the decoder.
 * Assumes both ends share pclk.
 */
`timescale 1ns/10ps
interface mmd_cfg_if;
   logic glob_en;
   logic prog_en;
   logic remap;
   logic ram1_en;
   logic ram2_en;
   logic flash_en;
   logic locked;
   logic boot;
   logic [2:0] last_tgt;
   modport regs (output glob_en, prog_en, remap, ram1_en, ram2_en, flash_en, locked, input boot, last_tgt);
   modport dec (input glob_en, prog_en, remap, ram1_en, ram2_en, flash_en, locked, output boot, last_tgt);
endinterface // mmd_cfg_if

// ---- include/mmd_pkg.sv ----
/*
 * Shared constants of the memory map decoder: address windows, register offsets,
 * configuration bit positions, reset values, target codes and access timing.
 * Assumes a 24-bit byte address from the CPU core and a 32-bit APB.
 */
package mmd_pkg;

   localparam int ADDR_W = 24;
   localparam int APB_AW = 8;

   // Target codes; the block number for the boot test block is outside the user range.
   typedef enum logic [2:0] {
      MMD_TGT_IFLASH = 3'h0,
      MMD_TGT_XFLASH = 3'h1,
      MMD_TGT_DUAL_PORT_INT_RAM = 3'h2,
      MMD_TGT_EXT_RAM_AREA1 = 3'h3,
      MMD_TGT_EXT_RAM_AREA2 = 3'h4,
      MMD_TGT_EXT = 3'h5,
      MMD_TGT_BLOCKED = 3'h6
   } mmd_tgt_e;

   typedef enum logic [1:0] {
      MMD_ST_IDLE = 2'h0,
      MMD_ST_DONE = 2'h1,
      MMD_ST_WAIT = 2'h2
   } mmd_state_e;

   // Region windows, inclusive bounds.
   localparam int NRGN = 9;
   localparam int RG_BOOT = 0;
   localparam int RG_SEG0 = 1;
   localparam int RG_SEG1 = 2;
   localparam int RG_UP = 3;
   localparam int RG_TOP = 4;
   localparam int RG_XF = 5;
   localparam int RG_X1 = 6;
   localparam int RG_X2 = 7;
   localparam int RG_DUAL_PORT_INT_RAM = 8;
   localparam logic [23:0] RGN_LO [NRGN] = '{24'h000000, 24'h000000, 24'h010000, 24'h018000, 24'h080000,
                                             24'h090000, 24'h00e000, 24'h0f0000, 24'h00f600};
   localparam logic [23:0] RGN_HI [NRGN] = '{24'h001fff, 24'h007fff, 24'h017fff, 24'h07ffff, 24'h08ffff,
                                             24'h0effff, 24'h00e7ff, 24'h0fffff, 24'h00fdff};

   // Segment numbers and flash block numbering.
   localparam logic [7:0] SEG_ONE = 8'h01;
   localparam logic [7:0] SEG_BANK3 = 8'h0c;
   localparam logic [7:0] SEG_XF_BASE = 8'h09;
   localparam logic [7:0] SEG_IF_OFS = 8'h03;
   localparam logic [3:0] BLK_SEG1 = 4'h4;
   localparam logic [3:0] BLK_TOP = 4'hb;
   localparam logic [3:0] BLK_BANK1 = 4'ha;
   localparam logic [3:0] BLK_XF_CTRL = 4'h5;
   localparam logic [3:0] BLK_TEST = 4'hf;
   localparam logic [1:0] BANK0 = 2'h0;
   localparam logic [1:0] BANK1 = 2'h1;
   localparam logic [1:0] BANK2 = 2'h2;
   localparam logic [1:0] BANK3 = 2'h3;

   // APB register offsets.
   localparam logic [7:0] OFS_SYS_CFG = 8'h00;
   localparam logic [7:0] OFS_XPER_CFG = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;

   // Configuration bit positions.
   localparam int SYS_GLOB_BIT = 2;
   localparam int SYS_PROG_BIT = 4;
   localparam int SYS_REMAP_BIT = 12;
   localparam int XP_RAM1_BIT = 2;
   localparam int XP_RAM2_BIT = 3;
   localparam int XP_FLASH_BIT = 5;
   localparam int ST_LOCK_BIT = 4;
   localparam int ST_BOOT_BIT = 5;

   localparam logic [31:0] SYS_CFG_RST = 32'h0000_0010;
   localparam logic [31:0] XPER_CFG_RST = 32'h0000_0000;

   // Extension RAM access time and the clock period, in picoseconds.
   localparam int XRAM_ACC_PS = 31250;
   localparam int CLK_PERIOD_PS = 50000;
   localparam int XRAM_ACC_CYC = (XRAM_ACC_PS / CLK_PERIOD_PS) < 1 ? 1 : XRAM_ACC_PS / CLK_PERIOD_PS;

endpackage

// ---- verilog/mmd_cfg_regs.sv ----
/*
 * APB slave holding the system and extension-peripheral configuration words and a status word.
 * Assumes an APB master on pclk; end_of_init arrives as a one-cycle pulse.
 */
`timescale 1ns/10ps
module mmd_cfg_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic end_of_init,
   mmd_cfg_if.regs cfg
);
   logic [31:0] sys_reg, sys_next, xper_reg, xper_next, prdata_reg, prdata_next;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next, lock_reg, lock_next;
   logic wr, hit;
   logic [31:0] rd;

   always_comb begin
      wr = psel && penable && pready_reg && pwrite;
      hit = (paddr == mmd_pkg::OFS_SYS_CFG) || (paddr == mmd_pkg::OFS_XPER_CFG) || (paddr == mmd_pkg::OFS_STATUS);
      sys_next = sys_reg;
      xper_next = xper_reg;
      lock_next = lock_reg || end_of_init;
      if (wr && paddr == mmd_pkg::OFS_SYS_CFG) begin
         sys_next = pwdata;
         // Segment remap freezes once initialisation has ended.
         if (lock_reg) begin
            sys_next[mmd_pkg::SYS_REMAP_BIT] = sys_reg[mmd_pkg::SYS_REMAP_BIT];
         end
      end
      if (wr && paddr == mmd_pkg::OFS_XPER_CFG) begin
         xper_next = pwdata;
      end
      rd = 32'h0000_0000;
      unique case (paddr)
         mmd_pkg::OFS_SYS_CFG: rd = sys_reg;
         mmd_pkg::OFS_XPER_CFG: rd = xper_reg;
         mmd_pkg::OFS_STATUS: begin
            rd[2:0] = cfg.last_tgt;
            rd[mmd_pkg::ST_LOCK_BIT] = lock_reg;
            rd[mmd_pkg::ST_BOOT_BIT] = cfg.boot;
         end
         default: rd = 32'h0000_0000;
      endcase
      pready_next = psel && penable && !pready_reg;
      prdata_next = pready_next ? rd : prdata_reg;
      pslverr_next = pready_next && !hit;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_reg <= mmd_pkg::SYS_CFG_RST;
         xper_reg <= mmd_pkg::XPER_CFG_RST;
         lock_reg <= 1'b0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         sys_reg <= sys_next;
         xper_reg <= xper_next;
         lock_reg <= lock_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign cfg.glob_en = sys_reg[mmd_pkg::SYS_GLOB_BIT];
   assign cfg.prog_en = sys_reg[mmd_pkg::SYS_PROG_BIT];
   assign cfg.remap = sys_reg[mmd_pkg::SYS_REMAP_BIT];
   assign cfg.ram1_en = xper_reg[mmd_pkg::XP_RAM1_BIT];
   assign cfg.ram2_en = xper_reg[mmd_pkg::XP_RAM2_BIT];
   assign cfg.flash_en = xper_reg[mmd_pkg::XP_FLASH_BIT];
   assign cfg.locked = lock_reg;
endmodule // mmd_cfg_regs

// ---- verilog/mmd_decoder.sv ----
/*
 * Memory map decoder: steers each CPU access in the 16 Mbyte space to on-chip program flash,
 * extension flash, dual-port internal RAM, one of two extension RAM areas, or the external bus, or refuses it as blocked.
 * Assumes a CPU that holds cpu_req with its qualifiers until cpu_ack, and flash banks that
 * report their program/erase activity on bank_busy.
 */
// Function
// - Decode full 16 Mbyte space, byte or word.
// - Program flash blocks, banks 0 and 1.
// - Hold reads while same flash bank busy.
// - Boot mode maps test block at zero.
// - Extension flash needs global and flash enable.
// - Global enable clear sends flash range external.
// - Extension flash banks 2, 3, control block.
// - Segment eight reserved when global and flash or RAM2 enable, program flash off.
// - Dual-port RAM holds the register bank.
// - Extension RAM: zero wait, one cycle.
// - RAM1 decoded when global and RAM1 enable.
// - RAM1 range external when either enable clear.
// - RAM2 decoded when global and RAM2 enable.
// - Disabled RAM2 range goes external.
// - No stack or bit ops in extension RAM.
// - Low flash blocks remap before end of init.
`timescale 1ns/10ps
module mmd_decoder (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic boot_mode,
   input wire logic end_of_init_instr,
   input wire logic [3:0] bank_busy,
   input wire logic cpu_req,
   input wire logic [23:0] cpu_addr,
   input wire logic cpu_write,
   input wire logic cpu_byte,
   input wire logic cpu_bitop,
   input wire logic cpu_stack,
   output logic cpu_ack,
   output logic [2:0] cpu_tgt,
   output logic cpu_err,
   output logic cpu_byte_out,
   output logic [1:0] flash_bank,
   output logic [3:0] flash_blk
);
   localparam int ACC_CYC = mmd_pkg::XRAM_ACC_CYC;

   mmd_cfg_if cfg ();
   logic [mmd_pkg::NRGN-1:0] hit;
   mmd_pkg::mmd_state_e st_reg, st_next;
   mmd_pkg::mmd_tgt_e tgt_reg, tgt_next, dtgt;
   logic ack_reg, ack_next, err_reg, err_next, byte_reg, byte_next, boot_reg, boot_next;
   logic [1:0] bank_reg, bank_next, dbank;
   logic [3:0] blk_reg, blk_next, dblk;
   logic is_flash, stall, derr, xf_on, x1_on, x2_on, res08, low_win;
   logic [7:0] seg;

   mmd_cfg_regs u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .end_of_init(end_of_init_instr),
      .cfg(cfg.regs)
   );

   genvar gi;
   generate
      for (gi = 0; gi < mmd_pkg::NRGN; gi++) begin : g_rgn
         mmd_range_hit #(.LO(mmd_pkg::RGN_LO[gi]), .HI(mmd_pkg::RGN_HI[gi])) u_hit (
            .addr(cpu_addr),
            .hit(hit[gi])
         );
      end
   endgenerate

   // Region decode, from the live enables on every cycle.
   always_comb begin
      seg = cpu_addr[23:16];
      xf_on = cfg.glob_en && cfg.flash_en;
      x1_on = cfg.glob_en && cfg.ram1_en;
      x2_on = cfg.glob_en && cfg.ram2_en;
      res08 = cfg.glob_en && (cfg.flash_en || cfg.ram2_en);
      low_win = cfg.remap ? hit[mmd_pkg::RG_SEG1] : hit[mmd_pkg::RG_SEG0];
      dtgt = mmd_pkg::MMD_TGT_EXT;
      dblk = 4'h0;
      dbank = mmd_pkg::BANK0;
      is_flash = 1'b0;
      derr = 1'b0;
      if (boot_mode && hit[mmd_pkg::RG_BOOT]) begin
         dtgt = mmd_pkg::MMD_TGT_IFLASH;
         dblk = mmd_pkg::BLK_TEST;
         is_flash = 1'b1;
      end else if (cfg.prog_en && low_win) begin
         dtgt = mmd_pkg::MMD_TGT_IFLASH;
         dblk = {2'h0, cpu_addr[14:13]};
         is_flash = 1'b1;
      end else if (cfg.prog_en && hit[mmd_pkg::RG_UP]) begin
         dtgt = mmd_pkg::MMD_TGT_IFLASH;
         dblk = (seg == mmd_pkg::SEG_ONE) ? mmd_pkg::BLK_SEG1 : 4'(seg + mmd_pkg::SEG_IF_OFS);
         dbank = (dblk >= mmd_pkg::BLK_BANK1) ? mmd_pkg::BANK1 : mmd_pkg::BANK0;
         is_flash = 1'b1;
      end else if (hit[mmd_pkg::RG_TOP]) begin
         if (cfg.prog_en) begin
            dtgt = mmd_pkg::MMD_TGT_IFLASH;
            dblk = mmd_pkg::BLK_TOP;
            dbank = mmd_pkg::BANK1;
            is_flash = 1'b1;
         end else if (res08) begin
            dtgt = mmd_pkg::MMD_TGT_BLOCKED;
            derr = 1'b1;
         end
      end else if (hit[mmd_pkg::RG_XF] && xf_on) begin
         dtgt = mmd_pkg::MMD_TGT_XFLASH;
         dblk = 4'(seg - mmd_pkg::SEG_XF_BASE);
         dbank = (seg < mmd_pkg::SEG_BANK3) ? mmd_pkg::BANK2 : mmd_pkg::BANK3;
         is_flash = (dblk != mmd_pkg::BLK_XF_CTRL);
      end else if (hit[mmd_pkg::RG_X1] && x1_on) begin
         dtgt = mmd_pkg::MMD_TGT_EXT_RAM_AREA1;
      end else if (hit[mmd_pkg::RG_X2] && x2_on) begin
         dtgt = mmd_pkg::MMD_TGT_EXT_RAM_AREA2;
      end else if (hit[mmd_pkg::RG_DUAL_PORT_INT_RAM]) begin
         dtgt = mmd_pkg::MMD_TGT_DUAL_PORT_INT_RAM;
      end
      // Extension RAM sits on the external-style bus, so stack and bit accesses are refused there.
      if ((dtgt == mmd_pkg::MMD_TGT_EXT_RAM_AREA1 || dtgt == mmd_pkg::MMD_TGT_EXT_RAM_AREA2) && (cpu_bitop || cpu_stack)) begin
         dtgt = mmd_pkg::MMD_TGT_BLOCKED;
         derr = 1'b1;
      end
      stall = is_flash && !cpu_write && bank_busy[dbank];
   end

   // Access handshake: one registered acknowledge per request.
   always_comb begin
      st_next = st_reg;
      ack_next = 1'b0;
      tgt_next = tgt_reg;
      err_next = 1'b0;
      byte_next = byte_reg;
      bank_next = bank_reg;
      blk_next = blk_reg;
      boot_next = boot_mode;
      unique case (st_reg)
         mmd_pkg::MMD_ST_IDLE, mmd_pkg::MMD_ST_WAIT: begin
            if (cpu_req) begin
               if (stall) begin
                  st_next = mmd_pkg::MMD_ST_WAIT;
               end else begin
                  st_next = mmd_pkg::MMD_ST_DONE;
                  ack_next = 1'b1;
                  tgt_next = dtgt;
                  err_next = derr;
                  byte_next = cpu_byte;
                  bank_next = dbank;
                  blk_next = dblk;
               end
            end else begin
               st_next = mmd_pkg::MMD_ST_IDLE;
            end
         end
         mmd_pkg::MMD_ST_DONE: st_next = mmd_pkg::MMD_ST_IDLE;
         default: st_next = mmd_pkg::MMD_ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= mmd_pkg::MMD_ST_IDLE;
         ack_reg <= 1'b0;
         tgt_reg <= mmd_pkg::MMD_TGT_EXT;
         err_reg <= 1'b0;
         byte_reg <= 1'b0;
         bank_reg <= mmd_pkg::BANK0;
         blk_reg <= 4'h0;
         boot_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         ack_reg <= ack_next;
         tgt_reg <= tgt_next;
         err_reg <= err_next;
         byte_reg <= byte_next;
         bank_reg <= bank_next;
         blk_reg <= blk_next;
         boot_reg <= boot_next;
      end
   end

   assign cfg.last_tgt = tgt_reg;
   assign cfg.boot = boot_reg;
   assign cpu_ack = ack_reg;
   assign cpu_tgt = tgt_reg;
   assign cpu_err = err_reg;
   assign cpu_byte_out = byte_reg;
   assign flash_bank = bank_reg;
   assign flash_blk = blk_reg;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_stall;
      (st_reg != mmd_pkg::MMD_ST_DONE && cpu_req && stall) |=> !ack_reg;
   endproperty
   a_stall: assert property (p_stall) else $error("read acked while its flash bank was busy");

   property p_acc_time;
      (st_reg == mmd_pkg::MMD_ST_IDLE && cpu_req && !stall) |-> ##ACC_CYC ack_reg ##1 !ack_reg;
   endproperty
   a_acc_time: assert property (p_acc_time) else $error("access not completed in one cycle");

   property p_boot;
      (ack_reg && $past(boot_mode) && $past(hit[mmd_pkg::RG_BOOT]))
         |-> (tgt_reg == mmd_pkg::MMD_TGT_IFLASH && blk_reg == mmd_pkg::BLK_TEST);
   endproperty
   a_boot: assert property (p_boot) else $error("boot test block not mapped at zero");

   property p_xf_off;
      (ack_reg && !$past(cfg.glob_en) && $past(hit[mmd_pkg::RG_XF])) |-> tgt_reg == mmd_pkg::MMD_TGT_EXT;
   endproperty
   a_xf_off: assert property (p_xf_off) else $error("flash range not external with global enable clear");

   property p_ext_ram_area1;
      (ack_reg && $past(hit[mmd_pkg::RG_X1]) && !$past(cpu_bitop) && !$past(cpu_stack))
         |-> ((tgt_reg == mmd_pkg::MMD_TGT_EXT_RAM_AREA1) == $past(cfg.glob_en && cfg.ram1_en));
   endproperty
   a_ext_ram_area1: assert property (p_ext_ram_area1) else $error("RAM1 decode does not follow its enables");

   property p_ext_ram_area2;
      (ack_reg && $past(hit[mmd_pkg::RG_X2]) && !$past(cpu_bitop) && !$past(cpu_stack))
         |-> ((tgt_reg == mmd_pkg::MMD_TGT_EXT_RAM_AREA2) == $past(cfg.glob_en && cfg.ram2_en));
   endproperty
   a_ext_ram_area2: assert property (p_ext_ram_area2) else $error("RAM2 decode does not follow its enables");

   property p_res08;
      (ack_reg && $past(hit[mmd_pkg::RG_TOP]) && $past(!cfg.prog_en && res08))
         |-> (tgt_reg == mmd_pkg::MMD_TGT_BLOCKED && err_reg);
   endproperty
   a_res08: assert property (p_res08) else $error("reserved segment reached the external bus");

   property p_bitop;
      (ack_reg && $past(cpu_bitop) && $past(hit[mmd_pkg::RG_X1] && x1_on)) |-> err_reg;
   endproperty
   a_bitop: assert property (p_bitop) else $error("bit access to extension RAM accepted");

   property p_xf_bank;
      (ack_reg && tgt_reg == mmd_pkg::MMD_TGT_XFLASH) |-> (bank_reg == mmd_pkg::BANK2 || bank_reg == mmd_pkg::BANK3);
   endproperty
   a_xf_bank: assert property (p_xf_bank) else $error("extension flash outside banks 2 and 3");

   property p_xf_on;
      (ack_reg && $past(hit[mmd_pkg::RG_XF] && xf_on)) |-> tgt_reg == mmd_pkg::MMD_TGT_XFLASH;
   endproperty
   a_xf_on: assert property (p_xf_on) else $error("enabled extension flash not decoded");

   property p_remap;
      (ack_reg && $past(cfg.remap && cfg.prog_en && hit[mmd_pkg::RG_SEG1]))
         |-> tgt_reg == mmd_pkg::MMD_TGT_IFLASH;
   endproperty
   a_remap: assert property (p_remap) else $error("remapped low blocks not decoded");

   property p_unclaimed;
      (ack_reg && $past(cpu_addr) > mmd_pkg::RGN_HI[mmd_pkg::RG_X2]) |-> tgt_reg == mmd_pkg::MMD_TGT_EXT;
   endproperty
   a_unclaimed: assert property (p_unclaimed) else $error("unclaimed address not external");

   property p_prog_off;
      (ack_reg && $past(!cfg.prog_en && hit[mmd_pkg::RG_UP])) |-> tgt_reg == mmd_pkg::MMD_TGT_EXT;
   endproperty
   a_prog_off: assert property (p_prog_off) else $error("disabled program flash decoded");

   property p_err_blk;
      ack_reg |-> (err_reg == (tgt_reg == mmd_pkg::MMD_TGT_BLOCKED));
   endproperty
   a_err_blk: assert property (p_err_blk) else $error("error flag without blocked target");

   property p_ack_once;
      ack_reg |=> !ack_reg;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("acknowledge longer than one cycle");

   property p_byte;
      ack_reg |-> byte_reg == $past(cpu_byte);
   endproperty
   a_byte: assert property (p_byte) else $error("byte flag lost");

   c_stall: cover property (st_reg == mmd_pkg::MMD_ST_WAIT ##1 ack_reg);
   c_ext_ram_area2: cover property (ack_reg && tgt_reg == mmd_pkg::MMD_TGT_EXT_RAM_AREA2);
   c_block: cover property (ack_reg && err_reg);
   c_remap: cover property (ack_reg && cfg.remap && tgt_reg == mmd_pkg::MMD_TGT_IFLASH);
   c_boot: cover property (ack_reg && blk_reg == mmd_pkg::BLK_TEST);
endmodule // mmd_decoder

// ---- verilog/mmd_range_hit.sv ----
/*
 * One inclusive address window compare.
 * Assumes a 24-bit byte address.
 */
`timescale 1ns/10ps
module mmd_range_hit #(
   parameter logic [23:0] LO = 24'h000000,
   parameter logic [23:0] HI = 24'h000000
) (
   input wire logic [23:0] addr,
   output logic hit
);
   assign hit = (addr >= LO) && (addr <= HI);
endmodule // mmd_range_hit
